// [verilog/pmsmb_pkg.sv]
`default_nettype none
package pmsmb_pkg;
    // Configuration byte offsets
    localparam logic [7:0] PM_BASE_OFF = 8'h40;
    localparam logic [7:0] PM_MISC_OFF = 8'h80;
    localparam logic [7:0] SMB_BASE_OFF = 8'h90;
    localparam logic [7:0] HOST_CFG_OFF = 8'hd2;
    localparam logic [7:0] SLV_CMD_OFF = 8'hd3;
    localparam logic [7:0] SHDW1_OFF = 8'hd4;
    localparam logic [7:0] SHDW2_OFF = 8'hd5;
    localparam logic [7:0] REV_OFF = 8'hd6;
    // Field positions
    localparam int unsigned PM_IO_SE_BIT = 0;
    localparam int unsigned HOST_EN_BIT = 0;
    localparam int unsigned IRQ_SEL_LSB = 1;
    localparam int unsigned SMB_BASE_LSB = 4;
    localparam int unsigned PM_BASE_LSB = 6;
    localparam int unsigned IO_ADDR_MSB = 15;
    localparam int unsigned SMB_BASE_W = IO_ADDR_MSB - SMB_BASE_LSB + 1;
    localparam int unsigned PM_BASE_W = IO_ADDR_MSB - PM_BASE_LSB + 1;
    // Interrupt route codes
    localparam logic [2:0] IRQ_SEL_MGMT = 3'h0;
    localparam logic [2:0] IRQ_SEL_NINE = 3'h4;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [SMB_BASE_W-1:0] SMB_BASE_RST = 12'h000;
    localparam logic [PM_BASE_W-1:0] PM_BASE_RST = 10'h000;
    localparam logic [2:0] IRQ_SEL_RST = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic RES_TYPE_IO = 1'b1;
    localparam logic [1:0] WORD_LANE_BYTE0 = 2'h0;
    localparam logic [1:0] WORD_LANE_BYTE1 = 2'h1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pmsmb_cfg_req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } pmsmb_io_req_type;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic rw;
        logic [7:0] cmd;
    } pmsmb_slv_req_type;
endpackage : pmsmb_pkg
`default_nettype wire

// [verilog/pmsmb_config_regs.sv]
`default_nettype none
module pmsmb_config_regs
    import pmsmb_pkg::*;
#(
    // Arbitrary revision value
    parameter logic [7:0] REV_CODE = 8'h5a
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Configuration access
    input wire pmsmb_cfg_req_type cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // I/O decode
    input wire logic function_io_space_enable,
    input wire pmsmb_io_req_type io_req,
    output logic pm_io_claim,
    output logic smbus_io_claim,
    // SMBus controller control
    input wire logic smbus_irq_event,
    output logic smbus_host_enable,
    output logic system_mgmt_interrupt,
    output logic legacy_irq_nine,
    // Slave matching
    input wire pmsmb_slv_req_type slv_req,
    output logic slave_result_valid,
    output logic command_hit,
    output logic shadow_one_hit,
    output logic shadow_two_hit
);
    logic pm_io_space_enable_reg;
    logic [PM_BASE_W-1:0] pm_base_reg;
    logic [SMB_BASE_W-1:0] smb_base_reg;
    logic [2:0] smbus_irq_select_reg;
    logic smbus_host_enable_reg;
    logic [7:0] slave_command_match_reg;
    logic [7:0] shadow_one_reg;
    logic [7:0] shadow_two_reg;
    logic [31:0] cfg_rdata_reg;
    logic [31:0] cfg_rdata_next;
    logic cfg_rvalid_reg;
    logic pm_io_claim_reg;
    logic smbus_io_claim_reg;
    logic mgmt_int_reg;
    logic irq_nine_reg;
    logic [7:0] misc_wbyte;
    logic [7:0] host_wbyte;
    logic slave_valid_reg;
    logic cmd_hit_reg;
    logic shdw1_hit_reg;
    logic shdw2_hit_reg;

    // Write strobe for one byte of configuration space
    function automatic logic lane_hit(input pmsmb_cfg_req_type req, input logic [7:0] off);
        lane_hit = req.wr && (req.addr[7:2] == off[7:2]) && req.be[off[1:0]];
    endfunction : lane_hit

    function automatic logic [7:0] lane_byte(input pmsmb_cfg_req_type req,
                                             input logic [7:0] off);
        lane_byte = req.wdata[{off[1:0], 3'h0} +: 8];
    endfunction : lane_byte

    function automatic logic [31:0] place_byte(input logic [7:0] val, input logic [7:0] off);
        place_byte = WORD_ZERO;
        place_byte[{off[1:0], 3'h0} +: 8] = val;
    endfunction : place_byte

    function automatic logic word_sel(input logic [7:0] addr, input logic [7:0] off);
        word_sel = (addr[7:2] == off[7:2]);
    endfunction : word_sel

    // Function results cannot be bit-selected, so the lanes are named here
    assign misc_wbyte = lane_byte(cfg_req, PM_MISC_OFF);
    assign host_wbyte = lane_byte(cfg_req, HOST_CFG_OFF);

    // Power-management enable; only bit 0 is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pm_io_space_enable_reg <= 1'b0;
        end else if (lane_hit(cfg_req, PM_MISC_OFF)) begin
            pm_io_space_enable_reg <= misc_wbyte[PM_IO_SE_BIT];
        end
    end

    // PM base, two low lanes of its dword
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pm_base_reg <= PM_BASE_RST;
        end else begin
            if (lane_hit(cfg_req, PM_BASE_OFF)) begin
                pm_base_reg[1:0] <= cfg_req.wdata[7:PM_BASE_LSB];
            end
            if (lane_hit(cfg_req, PM_BASE_OFF + 8'h01)) begin
                pm_base_reg[PM_BASE_W-1:2] <= cfg_req.wdata[15:8];
            end
        end
    end

    // SMBus base; upper lanes are hardwired, so writes there are dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            smb_base_reg <= SMB_BASE_RST;
        end else begin
            if (lane_hit(cfg_req, SMB_BASE_OFF)) begin
                smb_base_reg[3:0] <= cfg_req.wdata[7:SMB_BASE_LSB];
            end
            if (lane_hit(cfg_req, SMB_BASE_OFF + 8'h01)) begin
                smb_base_reg[SMB_BASE_W-1:4] <= cfg_req.wdata[15:8];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            smbus_irq_select_reg <= IRQ_SEL_RST;
            smbus_host_enable_reg <= 1'b0;
        end else if (lane_hit(cfg_req, HOST_CFG_OFF)) begin
            smbus_irq_select_reg <= host_wbyte[IRQ_SEL_LSB +: 3];
            smbus_host_enable_reg <= host_wbyte[HOST_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slave_command_match_reg <= BYTE_RST;
            shadow_one_reg <= BYTE_RST;
            shadow_two_reg <= BYTE_RST;
        end else begin
            if (lane_hit(cfg_req, SLV_CMD_OFF)) begin
                slave_command_match_reg <= lane_byte(cfg_req, SLV_CMD_OFF);
            end
            if (lane_hit(cfg_req, SHDW1_OFF)) begin
                shadow_one_reg <= lane_byte(cfg_req, SHDW1_OFF);
            end
            if (lane_hit(cfg_req, SHDW2_OFF)) begin
                shadow_two_reg <= lane_byte(cfg_req, SHDW2_OFF);
            end
        end
    end

    // Read mux; unmapped dwords read zero
    always_comb begin
        cfg_rdata_next = WORD_ZERO;
        if (word_sel(cfg_req.addr, PM_MISC_OFF)) begin
            cfg_rdata_next = place_byte({7'h00, pm_io_space_enable_reg}, PM_MISC_OFF);
        end else if (word_sel(cfg_req.addr, PM_BASE_OFF)) begin
            cfg_rdata_next = {16'h0000, pm_base_reg, 6'h00};
        end else if (word_sel(cfg_req.addr, SMB_BASE_OFF)) begin
            cfg_rdata_next = {16'h0000, smb_base_reg, 3'h0, RES_TYPE_IO};
        end else if (word_sel(cfg_req.addr, HOST_CFG_OFF)) begin
            cfg_rdata_next = place_byte({4'h0, smbus_irq_select_reg, smbus_host_enable_reg},
                                        HOST_CFG_OFF)
                           | place_byte(slave_command_match_reg, SLV_CMD_OFF);
        end else if (word_sel(cfg_req.addr, SHDW1_OFF)) begin
            cfg_rdata_next = place_byte(shadow_one_reg, SHDW1_OFF)
                           | place_byte(shadow_two_reg, SHDW2_OFF)
                           | place_byte(REV_CODE, REV_OFF);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata_reg <= WORD_ZERO;
            cfg_rvalid_reg <= 1'b0;
        end else begin
            cfg_rvalid_reg <= cfg_req.rd;
            if (cfg_req.rd) begin
                cfg_rdata_reg <= cfg_rdata_next;
            end
        end
    end

    // I/O claims; PM range does not look at the function-wide enable
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pm_io_claim_reg <= 1'b0;
            smbus_io_claim_reg <= 1'b0;
        end else begin
            pm_io_claim_reg <= io_req.valid && pm_io_space_enable_reg
                && (io_req.addr[IO_ADDR_MSB:PM_BASE_LSB] == pm_base_reg);
            smbus_io_claim_reg <= io_req.valid && function_io_space_enable
                && (io_req.addr[IO_ADDR_MSB:SMB_BASE_LSB] == smb_base_reg);
        end
    end

    // Reserved route codes deliver nowhere
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_int_reg <= 1'b0;
            irq_nine_reg <= 1'b0;
        end else begin
            mgmt_int_reg <= smbus_irq_event && smbus_host_enable_reg
                && (smbus_irq_select_reg == IRQ_SEL_MGMT);
            irq_nine_reg <= smbus_irq_event && smbus_host_enable_reg
                && (smbus_irq_select_reg == IRQ_SEL_NINE);
        end
    end

    // Shadow hits never match reads, since shadow entries only take writes; the command match ignores rw
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slave_valid_reg <= 1'b0;
            cmd_hit_reg <= 1'b0;
            shdw1_hit_reg <= 1'b0;
            shdw2_hit_reg <= 1'b0;
        end else begin
            slave_valid_reg <= slv_req.valid;
            cmd_hit_reg <= slv_req.valid && (slv_req.cmd == slave_command_match_reg);
            shdw1_hit_reg <= slv_req.valid && !slv_req.rw
                && ({slv_req.addr, slv_req.rw} == shadow_one_reg);
            shdw2_hit_reg <= slv_req.valid && !slv_req.rw
                && ({slv_req.addr, slv_req.rw} == shadow_two_reg);
        end
    end

    assign cfg_rdata = cfg_rdata_reg;
    assign cfg_rvalid = cfg_rvalid_reg;
    assign pm_io_claim = pm_io_claim_reg;
    assign smbus_io_claim = smbus_io_claim_reg;
    assign smbus_host_enable = smbus_host_enable_reg;
    assign system_mgmt_interrupt = mgmt_int_reg;
    assign legacy_irq_nine = irq_nine_reg;
    assign slave_result_valid = slave_valid_reg;
    assign command_hit = cmd_hit_reg;
    assign shadow_one_hit = shdw1_hit_reg;
    assign shadow_two_hit = shdw2_hit_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    pm_claim_gate_a: assert property (pm_io_claim |-> $past(pm_io_space_enable_reg))
        else $error("PM claim without enable");
    pm_claim_any_a: assert property (io_req.valid && pm_io_space_enable_reg
            && !function_io_space_enable
            && io_req.addr[IO_ADDR_MSB:PM_BASE_LSB] == pm_base_reg |=> pm_io_claim)
        else $error("PM claim missing with function I/O off");
    smb_high_zero_a: assert property (cfg_req.rd && word_sel(cfg_req.addr, SMB_BASE_OFF)
            |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[3:0] == 4'h1)
        else $error("SMBus base fixed bits wrong");
    smb_low_read_a: assert property (cfg_req.rd && word_sel(cfg_req.addr, SMB_BASE_OFF)
            |=> cfg_rdata[3:1] == 3'h0)
        else $error("SMBus base bits 3:1 not zero");
    smb_io_flag_a: assert property (cfg_rvalid
            && word_sel($past(cfg_req.addr), SMB_BASE_OFF) |-> cfg_rdata[0])
        else $error("SMBus base I/O flag not one");
    smb_decode_a: assert property (smbus_io_claim |-> $past(function_io_space_enable)
            && $past(io_req.addr[IO_ADDR_MSB:SMB_BASE_LSB]) == $past(smb_base_reg))
        else $error("SMBus claim outside base");
    smb_claim_gate_a: assert property (!function_io_space_enable |=> !smbus_io_claim)
        else $error("SMBus claim with function I/O off");
    irq_route_a: assert property ((smbus_irq_select_reg != IRQ_SEL_MGMT
            && smbus_irq_select_reg != IRQ_SEL_NINE) [*2]
            |-> !system_mgmt_interrupt && !legacy_irq_nine)
        else $error("Reserved route delivered interrupt");
    irq_deliver_a: assert property (smbus_irq_event && smbus_host_enable_reg
            && smbus_irq_select_reg == IRQ_SEL_NINE |=> legacy_irq_nine)
        else $error("Line nine interrupt missing");
    host_gate_a: assert property (!smbus_host_enable_reg [*2]
            |-> !system_mgmt_interrupt && !legacy_irq_nine)
        else $error("Interrupt while host disabled");
    host_enable_a: assert property (lane_hit(cfg_req, HOST_CFG_OFF)
            |=> smbus_host_enable == $past(host_wbyte[HOST_EN_BIT]))
        else $error("Host enable not written");
    cmd_match_a: assert property (slv_req.valid && slv_req.cmd == slave_command_match_reg
            |=> command_hit && slave_result_valid)
        else $error("Command match lost");
    write_only_a: assert property (shadow_one_hit || shadow_two_hit
            |-> !$past(slv_req.rw) && $past(slv_req.valid))
        else $error("Shadow hit on read");
    shadow_match_a: assert property (slv_req.valid && !slv_req.rw
            && {slv_req.addr, 1'b0} == shadow_two_reg |=> shadow_two_hit)
        else $error("Shadow two match lost");
    rev_read_a: assert property (cfg_req.rd && word_sel(cfg_req.addr, REV_OFF)
            |=> cfg_rdata[{REV_OFF[1:0], 3'h0} +: 8] == REV_CODE)
        else $error("Revision code wrong");
    misc_reserved_a: assert property (cfg_req.rd && word_sel(cfg_req.addr, PM_MISC_OFF)
            |=> cfg_rdata[31:1] == 31'h0)
        else $error("Reserved misc bits nonzero");

    pm_claim_c: cover property (pm_io_claim);
    smb_claim_c: cover property (smbus_io_claim);
    irq_nine_c: cover property (legacy_irq_nine);
    mgmt_int_c: cover property (system_mgmt_interrupt);
    shadow_c: cover property (shadow_one_hit && command_hit);
endmodule : pmsmb_config_regs
`default_nettype wire

// [tb/pmsmb_host_model.sv]
`default_nettype none
module pmsmb_host_model
    import pmsmb_pkg::*;
(
    // Clock
    input wire logic clk,
    // Configuration bus
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    output var pmsmb_cfg_req_type cfg_req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial cfg_req = '0;

    // Strobe lasts one cycle; an idle cycle follows, so calls never collide
    task cfg_write(input logic [7:0] addr, input logic [3:0] be, input logic [31:0] data);
        @(negedge clk);
        cfg_req = {1'b1, 1'b0, addr, be, data};
        @(negedge clk);
        cfg_req = '0;
    endtask : cfg_write

    // Answer stands one cycle only, so it is taken at the next falling edge
    task cfg_read(input logic [7:0] addr, output logic [31:0] data, output logic vld);
        @(negedge clk);
        cfg_req = {1'b0, 1'b1, addr, 4'h0, 32'h0};
        @(negedge clk);
        vld = cfg_rvalid;
        data = cfg_rdata;
        cfg_req = '0;
    endtask : cfg_read
endmodule : pmsmb_host_model
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb
    import pmsmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Arbitrary revision value
    localparam logic [7:0] REV_TB = 8'h3c;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    pmsmb_cfg_req_type cfg_req;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    logic func_en = 1'b0;
    pmsmb_io_req_type io_req = '0;
    logic pm_claim, smb_claim, irq_ev = 1'b0, host_en, mgmt_int, irq_nine;
    pmsmb_slv_req_type slv_req = '0;
    logic slv_vld, cmd_hit, sh1, sh2;
    int failures = 0;
    int num_checks = 0;

    always #50 clk = ~clk;

    pmsmb_host_model host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .cfg_req(cfg_req));

    pmsmb_config_regs #(.REV_CODE(REV_TB)) DUT (.clk(clk), .rstn(rstn), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .function_io_space_enable(func_en),
        .io_req(io_req), .pm_io_claim(pm_claim), .smbus_io_claim(smb_claim),
        .smbus_irq_event(irq_ev), .smbus_host_enable(host_en),
        .system_mgmt_interrupt(mgmt_int), .legacy_irq_nine(irq_nine), .slv_req(slv_req),
        .slave_result_valid(slv_vld), .command_hit(cmd_hit), .shadow_one_hit(sh1),
        .shadow_two_hit(sh2));

    task complete_run;
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic v;
        host.cfg_read(addr, d, v);
        chk({31'h0, v}, 32'h1);
        chk(d, exp);
    endtask : rd_chk

    task io_chk(input logic [15:0] a, input logic pm_exp, input logic smb_exp);
        @(negedge clk);
        io_req = {1'b1, a};
        @(negedge clk);
        io_req = '0;
        chk({30'h0, pm_claim, smb_claim}, {30'h0, pm_exp, smb_exp});
    endtask : io_chk

    task slv_chk(input logic [6:0] a, input logic rw, input logic [7:0] c, input logic [3:0] exp);
        @(negedge clk);
        slv_req = {1'b1, a, rw, c};
        @(negedge clk);
        slv_req = '0;
        chk({28'h0, slv_vld, cmd_hit, sh1, sh2}, {28'h0, exp});
    endtask : slv_chk

    task test_reset;
        rd_chk(PM_MISC_OFF, 32'h0);
        rd_chk(SMB_BASE_OFF, 32'h0000_0001);
        rd_chk(8'hd0, 32'h0);
        rd_chk(SHDW1_OFF, {8'h00, REV_TB, 16'h0000});
        rd_chk(8'h50, 32'h0);
    endtask : test_reset

    task test_smb_base;
        host.cfg_write(SMB_BASE_OFF, 4'hf, 32'h0000_fffe);
        rd_chk(SMB_BASE_OFF, 32'h0000_fff1);
        func_en = 1'b1;
        io_chk(16'hfff5, 1'b0, 1'b1);
        io_chk(16'hffe5, 1'b0, 1'b0);
        func_en = 1'b0;
        io_chk(16'hfff5, 1'b0, 1'b0);
    endtask : test_smb_base

    task test_pm;
        host.cfg_write(PM_BASE_OFF, 4'h3, 32'h0000_1240);
        rd_chk(PM_BASE_OFF, 32'h0000_1240);
        io_chk(16'h1250, 1'b0, 1'b0);
        host.cfg_write(PM_MISC_OFF, 4'h1, 32'h0000_00ff);
        rd_chk(PM_MISC_OFF, 32'h1);
        io_chk(16'h127f, 1'b1, 1'b0);
        io_chk(16'h1280, 1'b0, 1'b0);
        io_chk(16'h123f, 1'b0, 1'b0);
        host.cfg_write(PM_MISC_OFF, 4'h1, 32'h0);
        io_chk(16'h1250, 1'b0, 1'b0);
    endtask : test_pm

    task test_irq;
        irq_ev = 1'b1;
        for (int s = 0; s < 8; s++) begin
            host.cfg_write(8'hd0, 4'h4, {8'h00, 4'hf, s[2:0], 1'b1, 16'h0});
            rd_chk(8'hd0, {8'h00, 4'h0, s[2:0], 1'b1, 16'h0});
            chk({29'h0, host_en, mgmt_int, irq_nine}, {29'h0, 1'b1, s == 0, s == 4});
        end
        host.cfg_write(8'hd0, 4'h4, 32'h0);
        rd_chk(8'hd0, 32'h0);
        chk({29'h0, host_en, mgmt_int, irq_nine}, 32'h0);
        // Route stays set while the event drops: the line must follow the event
        host.cfg_write(8'hd0, 4'h4, {8'h00, 4'h0, IRQ_SEL_NINE, 1'b1, 16'h0});
        irq_ev = 1'b0;
        @(negedge clk);
        chk({29'h0, host_en, mgmt_int, irq_nine}, 32'h4);
    endtask : test_irq

    task test_slave;
        host.cfg_write(8'hd0, 4'h8, 32'ha500_0000);
        host.cfg_write(SHDW1_OFF, 4'h7, 32'h00ff_2256);
        rd_chk(SHDW1_OFF, {8'h00, REV_TB, 16'h2256});
        slv_chk(7'h2b, 1'b0, 8'ha5, 4'b1110);
        slv_chk(7'h11, 1'b0, 8'h00, 4'b1001);
        slv_chk(7'h2b, 1'b1, 8'ha5, 4'b1100);
        slv_chk(7'h12, 1'b0, 8'ha4, 4'b1000);
    endtask : test_slave

    // Mid-run reset must clear every programmed field
    task test_mid_reset;
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rd_chk(SMB_BASE_OFF, 32'h0000_0001);
        rd_chk(PM_BASE_OFF, 32'h0);
        rd_chk(8'hd0, 32'h0);
        rd_chk(SHDW1_OFF, {8'h00, REV_TB, 16'h0000});
        chk({29'h0, host_en, mgmt_int, irq_nine}, 32'h0);
        slv_chk(7'h00, 1'b0, 8'h00, 4'b1111);
    endtask : test_mid_reset

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        test_reset();
        test_smb_base();
        test_pm();
        test_irq();
        test_slave();
        test_mid_reset();
        complete_run();
    end

    // Whole run needs about 110 cycles; this 5000-cycle limit allows ample margin
    initial begin
        #(5000 * 100);
        failures++;
        complete_run();
    end
endmodule : tb
`default_nettype wire
